/* hdl/apsr_pkg.sv */
package apsr_pkg;
    // register port shape
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int AMP_W = 7;
    localparam int SIGN_BIT = 6;
    localparam int MAG_MSB = 5;
    localparam int MAG_W = 6;

    // segment table
    localparam int NUM_SEG = 8;
    localparam int SEG_IDX_W = 3;
    localparam logic [ADDR_W-1:0] SEG1_ADDR = 5'h08;
    localparam logic [ADDR_W-1:0] SEG2_ADDR = 5'h09;
    localparam logic [ADDR_W-1:0] SEG3_ADDR = 5'h0A;
    localparam logic [ADDR_W-1:0] SEG4_ADDR = 5'h0B;
    localparam logic [ADDR_W-1:0] SEG5_ADDR = 5'h0C;
    localparam logic [ADDR_W-1:0] SEG6_ADDR = 5'h0D;
    localparam logic [ADDR_W-1:0] SEG7_ADDR = 5'h0E;
    localparam logic [ADDR_W-1:0] SEG8_ADDR = 5'h0F;
    localparam logic [DATA_W-1:0] SEG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SEG_TIME_NS = 80;
    localparam int SEG_CYCLES = (SEG_TIME_NS / CLK_PERIOD_NS < 1) ? 1
                                : SEG_TIME_NS / CLK_PERIOD_NS;
    localparam int SEG_CNT_W = 8;

    typedef enum logic {
        APSR_IDLE,
        APSR_RUN
    } apsr_state_t;
endpackage

/* hdl/apsr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Eight consecutive segments together last exactly one master clock period.
// - Each segment register holds a 7-bit amplitude used during its slot.
// - Amplitude is signed magnitude: bit 6 sign, bits 5..0 magnitude.
// - Segments three to six sit at addresses 01010 through 01101.
// - Segment values shape the pulse only in arbitrary pulse mode.
// - Segments one and two sit at 01000 and 01001, same format.
// - Segments seven and eight sit at 01110 and 01111.
module apsr_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // host register port
    input wire logic [apsr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [apsr_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [apsr_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // pulse control
    input wire logic arb_mode,
    input wire logic tx_mark,
    // pulse generator drive
    output logic pulse_active,
    output logic [apsr_pkg::SEG_IDX_W-1:0] pulse_seg,
    output logic amp_sign,
    output logic [apsr_pkg::MAG_W-1:0] amp_mag
);
    logic [apsr_pkg::DATA_W-1:0] seg_reg [apsr_pkg::NUM_SEG];
    logic [apsr_pkg::DATA_W-1:0] next_seg_reg [apsr_pkg::NUM_SEG];
    logic [apsr_pkg::DATA_W-1:0] next_rdata;
    logic next_rvalid;
    logic next_active;
    logic [apsr_pkg::SEG_IDX_W-1:0] next_pseg;
    logic next_sign;
    logic [apsr_pkg::MAG_W-1:0] next_mag;
    logic seq_active;
    logic [apsr_pkg::SEG_IDX_W-1:0] seq_idx;
    logic [apsr_pkg::DATA_W-1:0] seg3_amplitude;
    logic [apsr_pkg::DATA_W-1:0] seg4_amplitude;
    logic [apsr_pkg::DATA_W-1:0] seg5_amplitude;
    logic [apsr_pkg::DATA_W-1:0] seg6_amplitude;

    // the table occupies 01000..01111, so the top two bits pick it
    function automatic logic hits_table(input logic [apsr_pkg::ADDR_W-1:0] a);
        return a[apsr_pkg::ADDR_W-1:apsr_pkg::SEG_IDX_W] ==
               apsr_pkg::SEG1_ADDR[apsr_pkg::ADDR_W-1:apsr_pkg::SEG_IDX_W];
    endfunction

    function automatic logic [apsr_pkg::SEG_IDX_W-1:0] slot_of(
        input logic [apsr_pkg::ADDR_W-1:0] a);
        return a[apsr_pkg::SEG_IDX_W-1:0] - apsr_pkg::SEG1_ADDR[apsr_pkg::SEG_IDX_W-1:0];
    endfunction

    assign seg3_amplitude = seg_reg[slot_of(apsr_pkg::SEG3_ADDR)];
    assign seg4_amplitude = seg_reg[slot_of(apsr_pkg::SEG4_ADDR)];
    assign seg5_amplitude = seg_reg[slot_of(apsr_pkg::SEG5_ADDR)];
    assign seg6_amplitude = seg_reg[slot_of(apsr_pkg::SEG6_ADDR)];

    apsr_seq u_seq (
        .clock(clock),
        .rst(rst),
        .start(tx_mark),
        .active(seq_active),
        .seg_idx(seq_idx)
    );

    // register writes; reserved bit 7 is kept and read back
    always_comb begin
        for (int i = 0; i < apsr_pkg::NUM_SEG; i++) begin
            next_seg_reg[i] = seg_reg[i];
        end
        if (reg_wr && hits_table(reg_addr)) begin
            next_seg_reg[slot_of(reg_addr)] = reg_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < apsr_pkg::NUM_SEG; i++) begin
                seg_reg[i] <= apsr_pkg::SEG_RESET;
            end
        end else begin
            for (int i = 0; i < apsr_pkg::NUM_SEG; i++) begin
                seg_reg[i] <= next_seg_reg[i];
            end
        end
    end

    // read path: one cycle after the strobe, unmapped reads give zero
    always_comb begin
        next_rvalid = reg_rd;
        next_rdata = reg_rdata;
        if (reg_rd) begin
            unique case (reg_addr)
                apsr_pkg::SEG3_ADDR: next_rdata = seg3_amplitude;
                apsr_pkg::SEG4_ADDR: next_rdata = seg4_amplitude;
                apsr_pkg::SEG5_ADDR: next_rdata = seg5_amplitude;
                apsr_pkg::SEG6_ADDR: next_rdata = seg6_amplitude;
                default: begin
                    if (hits_table(reg_addr)) begin
                        next_rdata = seg_reg[slot_of(reg_addr)];
                    end else begin
                        next_rdata = apsr_pkg::UNMAPPED_READ;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= apsr_pkg::UNMAPPED_READ;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            reg_rvalid <= next_rvalid;
        end
    end

    // amplitude drive; other modes see a quiet zero, not the table
    always_comb begin
        next_active = 1'b0;
        next_pseg = '0;
        next_sign = 1'b0;
        next_mag = '0;
        if (arb_mode && seq_active) begin
            next_active = 1'b1;
            next_pseg = seq_idx;
            next_sign = seg_reg[seq_idx][apsr_pkg::SIGN_BIT];
            next_mag = seg_reg[seq_idx][apsr_pkg::MAG_MSB:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pulse_active <= 1'b0;
            pulse_seg <= '0;
            amp_sign <= 1'b0;
            amp_mag <= '0;
        end else begin
            pulse_active <= next_active;
            pulse_seg <= next_pseg;
            amp_sign <= next_sign;
            amp_mag <= next_mag;
        end
    end
endmodule
`default_nettype wire

/* hdl/apsr_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module apsr_seq (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // start of a mark
    input wire logic start,
    // segment position
    output logic active,
    output logic [apsr_pkg::SEG_IDX_W-1:0] seg_idx
);
    localparam logic [apsr_pkg::SEG_CNT_W-1:0] CNT_LAST =
        apsr_pkg::SEG_CNT_W'(apsr_pkg::SEG_CYCLES - 1);
    localparam logic [apsr_pkg::SEG_IDX_W-1:0] SEG_LAST =
        apsr_pkg::SEG_IDX_W'(apsr_pkg::NUM_SEG - 1);

    apsr_pkg::apsr_state_t state, next_state;
    logic [apsr_pkg::SEG_CNT_W-1:0] cnt, next_cnt;
    logic [apsr_pkg::SEG_IDX_W-1:0] seg, next_seg;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_seg = seg;
        unique case (state)
            apsr_pkg::APSR_IDLE: begin
                if (start) begin
                    next_state = apsr_pkg::APSR_RUN;
                    next_cnt = '0;
                    next_seg = '0;
                end
            end
            apsr_pkg::APSR_RUN: begin
                if (start) begin
                    // a new mark always begins from segment one
                    next_cnt = '0;
                    next_seg = '0;
                end else if (cnt == CNT_LAST) begin
                    next_cnt = '0;
                    if (seg == SEG_LAST) begin
                        // eight equal slots make one master period
                        next_state = apsr_pkg::APSR_IDLE;
                        next_seg = '0;
                    end else begin
                        next_seg = seg + 1'b1;
                    end
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= apsr_pkg::APSR_IDLE;
            cnt <= '0;
            seg <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            seg <= next_seg;
        end
    end

    assign active = (state == apsr_pkg::APSR_RUN);
    assign seg_idx = seg;
endmodule
`default_nettype wire

/* sim/apsr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module apsr_host (
    // clock
    input wire logic clock,
    // register port
    output logic [apsr_pkg::ADDR_W-1:0] reg_addr,
    output logic [apsr_pkg::DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [apsr_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // idle bus shows the inverse so stale values never look valid
    task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic v);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(posedge clock);
        #1;
        q = reg_rdata;
        v = reg_rvalid;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule
`default_nettype wire

/* sim/apsr_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module apsr_regs_bench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic arb_mode = 1'b1;
    logic tx_mark = 1'b0;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, q;
    logic reg_wr, reg_rd, reg_rvalid, pulse_active, amp_sign, v;
    logic [2:0] pulse_seg;
    logic [5:0] amp_mag;
    int bad_count = 0;
    int check_count = 0;

    apsr_regs dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .arb_mode(arb_mode), .tx_mark(tx_mark), .pulse_active(pulse_active),
        .pulse_seg(pulse_seg), .amp_sign(amp_sign), .amp_mag(amp_mag));
    apsr_host host_u (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    initial begin
        forever #4 clock = ~clock;
    end

    function automatic logic [7:0] pat(input int k);
        return 8'hA5 + 8'h1D * 8'(k);
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
        host_u.access(1'b0, a, 8'h00, q, v);
        check({7'h00, v}, 8'h01);
        check(q, exp);
    endtask
    task automatic kick();
        @(posedge clock);
        #1 tx_mark = 1'b1;
        @(posedge clock);
        #1 tx_mark = 1'b0;
    endtask
    // samples mid-segment so each check sits well inside its slot
    task automatic play(input logic mode);
        logic [7:0] e;
        kick();
        for (int k = 0; k < 8; k++) begin
            repeat (k == 0 ? 7 : 10) @(posedge clock);
            #1;
            e = pat(k);
            check({pulse_active, amp_sign, amp_mag}, mode ? {1'b1, e[6:0]} : 8'h00);
            check({5'h00, pulse_seg}, mode ? 8'(k) : 8'h00);
        end
        repeat (10) @(posedge clock);
        #1;
        check({pulse_active, amp_sign, amp_mag}, 8'h00);
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge clock);
        #1 rst = 1'b0;
        for (int k = 0; k < 8; k++) rchk(apsr_pkg::SEG1_ADDR + 5'(k), apsr_pkg::SEG_RESET);
        for (int k = 0; k < 8; k++) host_u.access(1'b1, apsr_pkg::SEG1_ADDR + 5'(k), pat(k), q, v);
        host_u.access(1'b1, 5'h10, 8'hFF, q, v);
        host_u.access(1'b1, 5'h07, 8'hFF, q, v);
        for (int k = 0; k < 8; k++) rchk(apsr_pkg::SEG1_ADDR + 5'(k), pat(k));
        rchk(5'h10, apsr_pkg::UNMAPPED_READ);
        rchk(5'h07, apsr_pkg::UNMAPPED_READ);
        play(1'b1);
        kick();
        repeat (36) @(posedge clock);
        play(1'b1);
        kick();
        repeat (20) @(posedge clock);
        #1 arb_mode = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check({pulse_active, amp_sign, amp_mag}, 8'h00);
        play(1'b0);
        close_out();
    end
endmodule
`default_nettype wire

/* sim/apsr_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module apsr_regs_sva (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // pulse side
    input wire logic arb_mode,
    input wire logic tx_mark,
    input wire logic pulse_active,
    input wire logic [2:0] pulse_seg,
    input wire logic amp_sign,
    input wire logic [5:0] amp_mag
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_read_latency: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    a_no_spurious: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read valid without read");
    a_unmapped_zero: assert property (reg_rd && reg_addr[4:3] != 2'b01 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved without read");
    a_mode_gate: assert property ((!arb_mode)[*2] |-> !pulse_active && amp_mag == 6'h00)
        else $error("pulse out of arbitrary mode");
    a_idle_zero: assert property (!pulse_active |-> pulse_seg == 3'h0 && !amp_sign && amp_mag == 6'h00)
        else $error("idle outputs not zero");
    a_mark_start: assert property ((tx_mark && arb_mode) ##1 arb_mode |=> pulse_active && pulse_seg == 3'h0)
        else $error("mark did not start segment one");
    a_seg_step: assert property (pulse_active && $past(pulse_active) && $changed(pulse_seg)
        |-> pulse_seg == $past(pulse_seg) + 3'h1 || pulse_seg == 3'h0)
        else $error("segment order broken");
    a_seg_hold: assert property ($rose(pulse_active) |-> pulse_seg == 3'h0 ##1 (pulse_seg == 3'h0)[*8])
        else $error("first segment too short");
    a_seg_end: assert property ($fell(pulse_active) && arb_mode |-> $past(pulse_seg) == 3'h7)
        else $error("pulse ended before segment eight");

    cover property ($rose(pulse_active));
    cover property (pulse_active && pulse_seg == 3'h7);
    cover property (reg_rvalid && reg_rdata != 8'h00);
endmodule
bind apsr_regs apsr_regs_sva chk_u (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .arb_mode(arb_mode), .tx_mark(tx_mark),
    .pulse_active(pulse_active), .pulse_seg(pulse_seg), .amp_sign(amp_sign), .amp_mag(amp_mag));
`default_nettype wire
